// ### core/dacfe_top.sv
// write-only two-wire serial slave front end of a single voltage dac
// assumes scl, sda, address pins and ref select are asynchronous pins,
// sda and address pins resolved outside from out/oe, registers via AXI4-Lite
//
// Functional notes
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - sample data on rising scl
// - sda released while receiving, low only acking
// - ack low through whole ack high period
// - never ack a read address
// - each address pin sensed as three states
// - two-pin address table
// - single-pin address table
// - global address also accepted
// - drive address pins to sense floating
// - zero variant resets code to zero
// - mid variant resets code to mid-scale
// - ref select pin picks power-up reference in single-pin variant; two-pin powers up internal
// - ref select ignored after power-up
// - hold n-bit code driving the output
// - ack three bytes then execute command
// - bytes past third left unacknowledged
`timescale 1ns/100ps
module dacfe_top #(
    parameter int N         = 12,
    parameter bit TWO_PIN   = 1'b1,
    parameter bit MID_RESET = 1'b0
) (
    // clock and reset
    input  wire  logic         clock,
    input  wire  logic         resetn,
    // serial bus
    input  wire  logic         scl_i,
    input  wire  logic         sda_i,
    output logic               sda_o,
    output logic               sda_oe,
    // address select and reference select pins
    input  wire  logic         addr_sel_pin0_i,
    output logic               addr_sel_pin0_o,
    output logic               addr_sel_pin0_oe,
    input  wire  logic         addr_sel_pin1_i,
    output logic               addr_sel_pin1_o,
    output logic               addr_sel_pin1_oe,
    input  wire  logic         ref_sel_i,
    // dac state
    output logic [N-1:0]       dac_code,
    output logic               dac_pd,
    output logic               ref_internal,
    // AXI4-Lite slave
    input  wire  logic [3:0]   awaddr,
    input  wire  logic         awvalid,
    output logic               awready,
    input  wire  logic [31:0]  wdata,
    input  wire  logic [3:0]   wstrb,
    input  wire  logic         wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire  logic         bready,
    input  wire  logic [3:0]   araddr,
    input  wire  logic         arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire  logic         rready
);
    import dacfe_pkg::*;

    localparam logic [N-1:0] RST_CODE = MID_RESET ? N'(1) << (N-1) : '0;

    // ************************************
    // pin synchronisers
    // ************************************
    logic [1:0] scl_m, sda_m, p0_m, p1_m, rs_m;
    logic       scl_d;
    logic       sda_d;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scl_m <= 2'h3;
            sda_m <= 2'h3;
            p0_m  <= 2'h0;
            p1_m  <= 2'h0;
            rs_m  <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= {scl_m[0], scl_i};
            sda_m <= {sda_m[0], sda_i};
            p0_m  <= {p0_m[0], addr_sel_pin0_i};
            p1_m  <= {p1_m[0], addr_sel_pin1_i};
            rs_m  <= {rs_m[0], ref_sel_i};
            scl_d <= scl_m[1];
            sda_d <= sda_m[1];
        end
    end

    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    assign scl_s     = scl_m[1];
    assign sda_s     = sda_m[1];
    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

    // ************************************
    // register bus
    // ************************************
    logic        awready_r, awready_nxt, wready_r, wready_nxt;
    logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [3:0]  awaddr_r, awaddr_nxt;
    logic [3:0]  wstrb_r, wstrb_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic        en_r, en_nxt;
    logic [31:0] status_w, code_w;

    logic [N-1:0] dac_r, dac_nxt, inp_r, inp_nxt;
    logic         pd_r, pd_nxt, refi_r, refi_nxt;
    logic [6:0]   own_addr_r, own_addr_nxt;
    dacfe_dt_e    dt_r, dt_nxt;

    assign status_w = {21'h0, pd_r, refi_r, (dt_r == DT_DONE), 1'b0, own_addr_r};
    assign code_w   = {16'(inp_r), 16'(dac_r)};

    always_comb begin
        awready_nxt = awready_r;
        wready_nxt  = wready_r;
        aw_got_nxt  = aw_got_r;
        w_got_nxt   = w_got_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        arready_nxt = arready_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        en_nxt      = en_r;
        if (awvalid && awready_r) begin
            aw_got_nxt  = 1'b1;
            awaddr_nxt  = awaddr;
            awready_nxt = 1'b0;
        end
        if (wvalid && wready_r) begin
            w_got_nxt  = 1'b1;
            wdata_nxt  = wdata;
            wstrb_nxt  = wstrb;
            wready_nxt = 1'b0;
        end
        if (aw_got_r && w_got_r) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = RESP_OKAY;
            if (awaddr_r == OFS_CTRL) begin
                if (wstrb_r[0]) begin
                    en_nxt = wdata_r[0];
                end
            end else if (awaddr_r != OFS_STATUS && awaddr_r != OFS_CODE) begin
                bresp_nxt = RESP_SLVERR;
            end
        end
        if (bvalid_r && bready) begin
            bvalid_nxt  = 1'b0;
            awready_nxt = 1'b1;
            wready_nxt  = 1'b1;
        end
        if (arvalid && arready_r) begin
            arready_nxt = 1'b0;
            rvalid_nxt  = 1'b1;
            rresp_nxt   = RESP_OKAY;
            unique case (araddr)
                OFS_CTRL:   rdata_nxt = {31'h0, en_r};
                OFS_STATUS: rdata_nxt = status_w;
                OFS_CODE:   rdata_nxt = code_w;
                default: begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_r && rready) begin
            rvalid_nxt  = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= 4'h0;
            wdata_r   <= 32'h0;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0;
            rresp_r   <= RESP_OKAY;
            en_r      <= CTRL_EN_RST;
        end else begin
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            en_r      <= en_nxt;
        end
    end

    // ************************************
    // pin sensing and dac state
    // ************************************
    // a floating pin keeps the level last driven; a tied pin does not
    logic [4:0]  dcnt_r, dcnt_nxt;
    logic [1:0]  hi_r, hi_nxt;
    logic        pin_o_r, pin_o_nxt, pin_oe_r, pin_oe_nxt;
    logic        exec_r;
    logic [23:0] word_r;
    logic [1:0]  c0, c1;
    logic [3:0]  idx;

    always_comb begin
        dt_nxt       = dt_r;
        dcnt_nxt     = dcnt_r + 5'h1;
        hi_nxt       = hi_r;
        pin_o_nxt    = pin_o_r;
        pin_oe_nxt   = pin_oe_r;
        own_addr_nxt = own_addr_r;
        dac_nxt      = dac_r;
        inp_nxt      = inp_r;
        pd_nxt       = pd_r;
        refi_nxt     = refi_r;
        c0  = {p0_m[1], hi_r[0]} == 2'b11 ? PIN_VCC :
              {p0_m[1], hi_r[0]} == 2'b00 ? PIN_GND : PIN_FLOAT;
        c1  = {p1_m[1], hi_r[1]} == 2'b11 ? PIN_VCC :
              {p1_m[1], hi_r[1]} == 2'b00 ? PIN_GND : PIN_FLOAT;
        idx = TWO_PIN ? 4'(c1) * 4'h3 + 4'(c0) : 4'(c0);
        unique case (dt_r)
            DT_DRVHI: if (dcnt_r == DET_DRV_CYC) begin
                dt_nxt     = DT_SMPHI;
                dcnt_nxt   = 5'h0;
                pin_oe_nxt = 1'b0;
            end
            DT_SMPHI: if (dcnt_r == DET_SMP_CYC) begin
                dt_nxt     = DT_DRVLO;
                dcnt_nxt   = 5'h0;
                hi_nxt     = {p1_m[1], p0_m[1]};
                pin_o_nxt  = 1'b0;
                pin_oe_nxt = 1'b1;
            end
            DT_DRVLO: if (dcnt_r == DET_DRV_CYC) begin
                dt_nxt     = DT_SMPLO;
                dcnt_nxt   = 5'h0;
                pin_oe_nxt = 1'b0;
            end
            DT_SMPLO: if (dcnt_r == DET_SMP_CYC) begin
                dt_nxt       = DT_DONE;
                own_addr_nxt = ADDR_TABLE[idx];
                refi_nxt     = TWO_PIN ? 1'b1 : rs_m[1];
            end
            DT_DONE: dcnt_nxt = dcnt_r;
        endcase
        if (exec_r) begin
            unique case (word_r[23:20])
                CMD_WRITE:    inp_nxt = word_r[15 -: N];
                CMD_UPDATE: begin
                    dac_nxt = inp_r;
                    pd_nxt  = 1'b0;
                end
                CMD_WR_UPD: begin
                    inp_nxt = word_r[15 -: N];
                    dac_nxt = word_r[15 -: N];
                    pd_nxt  = 1'b0;
                end
                CMD_PWR_DOWN: pd_nxt   = 1'b1;
                CMD_REF_INT:  refi_nxt = 1'b1;
                CMD_REF_EXT:  refi_nxt = 1'b0;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dt_r       <= DT_DRVHI;
            dcnt_r     <= 5'h0;
            hi_r       <= 2'h0;
            pin_o_r    <= 1'b1;
            pin_oe_r   <= 1'b1;
            own_addr_r <= ADDR_TABLE[0];
            dac_r      <= RST_CODE;
            inp_r      <= RST_CODE;
            pd_r       <= 1'b0;
            refi_r     <= 1'b0;
        end else begin
            dt_r       <= dt_nxt;
            dcnt_r     <= dcnt_nxt;
            hi_r       <= hi_nxt;
            pin_o_r    <= pin_o_nxt;
            pin_oe_r   <= pin_oe_nxt;
            own_addr_r <= own_addr_nxt;
            dac_r      <= dac_nxt;
            inp_r      <= inp_nxt;
            pd_r       <= pd_nxt;
            refi_r     <= refi_nxt;
        end
    end

    // ************************************
    // serial slave
    // ************************************
    dacfe_st_e   st_r, st_nxt;
    logic [2:0]  bit_r, bit_nxt, byte_r, byte_nxt;
    logic [7:0]  sh_r, sh_nxt;
    logic        pend_r, pend_nxt, ackgo_r, ackgo_nxt, xpend_r, xpend_nxt;
    logic        oe_r, oe_nxt, exec_nxt;
    logic [23:0] word_nxt;
    logic [7:0]  rx_byte;

    assign rx_byte = {sh_r[6:0], sda_s};

    always_comb begin
        st_nxt    = st_r;
        bit_nxt   = bit_r;
        byte_nxt  = byte_r;
        sh_nxt    = sh_r;
        pend_nxt  = pend_r;
        ackgo_nxt = ackgo_r;
        xpend_nxt = xpend_r;
        oe_nxt    = oe_r;
        word_nxt  = word_r;
        exec_nxt  = 1'b0;
        if (start_det) begin
            st_nxt    = ST_ADDR;
            bit_nxt   = 3'h0;
            byte_nxt  = 3'h0;
            pend_nxt  = 1'b0;
            xpend_nxt = 1'b0;
            oe_nxt    = 1'b0;
        end else if (stop_det) begin
            st_nxt    = ST_IDLE;
            bit_nxt   = 3'h0;
            byte_nxt  = 3'h0;
            pend_nxt  = 1'b0;
            xpend_nxt = 1'b0;
            oe_nxt    = 1'b0;
        end else if (scl_rise && (st_r == ST_ADDR || st_r == ST_DATA)) begin
            sh_nxt  = rx_byte;
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
                pend_nxt = 1'b1;
                if (st_r == ST_ADDR) begin
                    // reads and foreign addresses drop to ignore: no ack
                    ackgo_nxt = 1'b1;
                    if (!en_r || dt_r != DT_DONE || rx_byte[0] ||
                        (rx_byte[7:1] != own_addr_r &&
                         rx_byte[7:1] != ADDR_GLOBAL)) begin
                        st_nxt   = ST_IGN;
                        pend_nxt = 1'b0;
                    end
                end else if (byte_r < DATA_BYTES) begin
                    ackgo_nxt = 1'b1;
                    word_nxt  = {word_r[15:0], rx_byte};
                    byte_nxt  = byte_r + 3'h1;
                    xpend_nxt = (byte_r == DATA_BYTES - 3'h1);
                end else begin
                    ackgo_nxt = 1'b0;
                end
            end
        end else if (scl_fall && pend_r) begin
            st_nxt   = ST_ACK;
            pend_nxt = 1'b0;
            oe_nxt   = ackgo_r;
        end else if (scl_fall && st_r == ST_ACK) begin
            st_nxt    = ST_DATA;
            oe_nxt    = 1'b0;
            exec_nxt  = xpend_r;
            xpend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_r    <= ST_IDLE;
            bit_r   <= 3'h0;
            byte_r  <= 3'h0;
            sh_r    <= 8'h0;
            pend_r  <= 1'b0;
            ackgo_r <= 1'b0;
            xpend_r <= 1'b0;
            oe_r    <= 1'b0;
            word_r  <= 24'h0;
            exec_r  <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            bit_r   <= bit_nxt;
            byte_r  <= byte_nxt;
            sh_r    <= sh_nxt;
            pend_r  <= pend_nxt;
            ackgo_r <= ackgo_nxt;
            xpend_r <= xpend_nxt;
            oe_r    <= oe_nxt;
            word_r  <= word_nxt;
            exec_r  <= exec_nxt;
        end
    end

    // ************************************
    // outputs, all registered except the constant sda_o
    // ************************************
    assign sda_o            = 1'b0; // open drain: only the enable moves
    assign sda_oe           = oe_r;
    assign addr_sel_pin0_o  = pin_o_r;
    assign addr_sel_pin0_oe = pin_oe_r;
    assign addr_sel_pin1_o  = pin_o_r;
    assign addr_sel_pin1_oe = pin_oe_r & TWO_PIN;
    assign dac_code         = dac_r;
    assign dac_pd           = pd_r;
    assign ref_internal     = refi_r;
    assign awready          = awready_r;
    assign wready           = wready_r;
    assign bvalid           = bvalid_r;
    assign bresp            = bresp_r;
    assign arready          = arready_r;
    assign rvalid           = rvalid_r;
    assign rdata            = rdata_r;
    assign rresp            = rresp_r;

    // ************************************
    // checks
    // ************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    a_start_clears: assert property (start_det |=> st_r == ST_ADDR && bit_r == 3'h0
        && byte_r == 3'h0 && !oe_r) else $error("start did not reset receiver");
    a_stop_idle: assert property (stop_det |=> st_r == ST_IDLE && !oe_r)
        else $error("stop did not free the slave");
    a_rx_release: assert property ((st_r == ST_ADDR || st_r == ST_DATA) |-> !oe_r)
        else $error("sda driven while receiving");
    a_ack_steady: assert property (st_r == ST_ACK && scl_s && oe_r |=> oe_r || scl_fall
        || start_det || stop_det || $past(stop_det))
        else $error("ack dropped during high");
    a_read_noack: assert property (scl_rise && st_r == ST_ADDR && bit_r == 3'h7 && sda_s
        && !start_det && !stop_det |=> st_r == ST_IGN ##1 !oe_r)
        else $error("read address acknowledged");
    a_extra_nack: assert property (scl_rise && st_r == ST_DATA && bit_r == 3'h7
        && byte_r == DATA_BYTES && !start_det && !stop_det |=> !ackgo_r)
        else $error("extra byte acknowledged");
    a_pin_drive: assert property ((dt_r == DT_DRVHI || dt_r == DT_DRVLO) |-> pin_oe_r)
        else $error("address pin not driven");
    a_reset_code: assert property ($rose(dt_r == DT_DONE) |-> dac_r == RST_CODE
        && inp_r == RST_CODE) else $error("power-up code wrong");
    a_ref_hold: assert property (dt_r == DT_DONE && !exec_r |=> $stable(refi_r))
        else $error("reference moved without command");
    a_exec_three: assert property (exec_r |-> byte_r == DATA_BYTES && $past(st_r, 2)
        == ST_ACK) else $error("command run early");

endmodule

// ### core/dacfe_pkg.sv
// constants, states and register map of the dac serial front end
// assumes one 125 MHz core clock; nothing here is synthesised by itself
package dacfe_pkg;

    // ************************************
    // serial addressing
    // ************************************
    localparam logic [6:0] ADDR_GLOBAL = 7'h73;
    localparam logic [6:0] ADDR_TABLE [9] = '{7'h10, 7'h11, 7'h12, 7'h13,
                                             7'h20, 7'h21, 7'h22, 7'h23, 7'h30};
    localparam logic [1:0] PIN_GND   = 2'h0;
    localparam logic [1:0] PIN_FLOAT = 2'h1;
    localparam logic [1:0] PIN_VCC   = 2'h2;
    localparam logic [2:0] DATA_BYTES = 3'h3;

    // ************************************
    // commands (upper nibble of first data byte)
    // ************************************
    localparam logic [3:0] CMD_WRITE    = 4'h0;
    localparam logic [3:0] CMD_UPDATE   = 4'h1;
    localparam logic [3:0] CMD_WR_UPD   = 4'h3;
    localparam logic [3:0] CMD_PWR_DOWN = 4'h4;
    localparam logic [3:0] CMD_REF_INT  = 4'h6;
    localparam logic [3:0] CMD_REF_EXT  = 4'h7;

    // ************************************
    // pin sensing timing, in core cycles
    // ************************************
    localparam logic [4:0] DET_DRV_CYC = 5'h10;
    localparam logic [4:0] DET_SMP_CYC = 5'h04;

    // ************************************
    // register map and reset values
    // ************************************
    localparam logic [3:0]  OFS_CTRL   = 4'h0;
    localparam logic [3:0]  OFS_STATUS = 4'h4;
    localparam logic [3:0]  OFS_CODE   = 4'h8;
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_DATA = 5'b00100,
        ST_ACK  = 5'b01000,
        ST_IGN  = 5'b10000
    } dacfe_st_e;

    typedef enum logic [4:0] {
        DT_DRVHI = 5'b00001,
        DT_SMPHI = 5'b00010,
        DT_DRVLO = 5'b00100,
        DT_SMPLO = 5'b01000,
        DT_DONE  = 5'b10000
    } dacfe_dt_e;

endpackage

// ### tb/dacfe_master.sv
// two-wire bus master model, open-drain data, 125 ns per bit
// assumes the bench resolves sda from all three enables with a pull-up
`timescale 1ns/100ps
module dacfe_master (
    // bus
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe
);
    // ****************
    // bit timing
    // ****************
    localparam realtime Q = 31.25;
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // also serves as repeated start
    task automatic start();
        sda_oe = 1'b0;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_oe = 1'b1;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b0;
        #(2*Q);
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        logic e;
        for (int i = 7; i >= 0; i--) begin
            sda_oe = ~b[i];
            #Q scl = 1'b1;
            #(2*Q) scl = 1'b0;
            #Q;
        end
        sda_oe = 1'b0;
        #Q scl = 1'b1;
        #1 e = sda;
        // low at both ends of the high period
        #(2*Q-2) ack = ~e & ~sda;
        #1 scl = 1'b0;
        #Q;
    endtask
endmodule

// ### tb/dacfe_top_bench.sv
// bench of the dac serial front end, two-pin zero-reset and single-pin mid-reset 12-bit builds
// assumes dacfe_master drives the bus; pins modelled here
`timescale 1ns/100ps
module dacfe_top_bench;
    import dacfe_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, ref_sel = 1'b0;
    logic scl, m_oe, sda_o, sda_oe, p0_o, p0_oe, p1_o, p1_oe;
    logic p0_q = 1'b0, p1_q = 1'b0, dac_pd, ref_internal;
    logic [1:0] st0 = PIN_GND, st1 = PIN_GND, bresp, rresp;
    logic [11:0] dac_code;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata;
    int failures = 0, cmp_count = 0;
    // second build: single pin, mid reset, reference from its pin
    logic pb_o, pb_oe, pb_q = 1'b0, sdb_o, sdb_oe, ref_b;
    logic [11:0] dac_b;
    wire sda = ~(m_oe | (sda_oe & ~sda_o) | (sdb_oe & ~sdb_o));
    // floating pin keeps the charge last driven onto it
    wire pin0 = st0 == PIN_VCC | (st0 == PIN_FLOAT & (p0_oe ? p0_o : p0_q));
    wire pin1 = st1 == PIN_VCC | (st1 == PIN_FLOAT & (p1_oe ? p1_o : p1_q));
    wire pinb = st0 == PIN_VCC | (st0 == PIN_FLOAT & (pb_oe ? pb_o : pb_q));
    always #4 clock = ~clock;
    always @(posedge clock) begin
        if (p0_oe)
            p0_q <= p0_o;
        if (p1_oe)
            p1_q <= p1_o;
        if (pb_oe)
            pb_q <= pb_o;
    end
    dacfe_master dacfe_master_inst (.sda(sda), .scl(scl), .sda_oe(m_oe));
    dacfe_top #(.N(12), .TWO_PIN(1'b1), .MID_RESET(1'b0)) dacfe_top_inst (
        .clock(clock), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_sel_pin0_i(pin0), .addr_sel_pin0_o(p0_o),
        .addr_sel_pin0_oe(p0_oe), .addr_sel_pin1_i(pin1), .addr_sel_pin1_o(p1_o),
        .addr_sel_pin1_oe(p1_oe), .ref_sel_i(ref_sel), .dac_code(dac_code),
        .dac_pd(dac_pd), .ref_internal(ref_internal), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    dacfe_top #(.N(12), .TWO_PIN(1'b0), .MID_RESET(1'b1)) dacfe_top_inst2 (
        .clock(clock), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sdb_o),
        .sda_oe(sdb_oe), .addr_sel_pin0_i(pinb), .addr_sel_pin0_o(pb_o),
        .addr_sel_pin0_oe(pb_oe), .addr_sel_pin1_i(1'b0), .addr_sel_pin1_o(),
        .addr_sel_pin1_oe(), .ref_sel_i(ref_sel), .dac_code(dac_b), .dac_pd(),
        .ref_internal(ref_b), .awaddr(4'h0), .awvalid(1'b0), .awready(), .wdata(32'h0),
        .wstrb(4'h0), .wvalid(1'b0), .wready(), .bresp(), .bvalid(), .bready(1'b0),
        .araddr(4'h0), .arvalid(1'b0), .arready(), .rdata(), .rresp(), .rvalid(),
        .rready(1'b0));
    // ****************
    // shared tasks
    // ****************
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        if (n == 40) begin
            failures++;
            conclude();
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        if (n == 40) begin
            failures++;
            conclude();
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] a, input logic [23:0] w, input int nb,
                        output logic [4:0] acks);
        logic k;
        acks = 5'h00;
        dacfe_master_inst.start();
        dacfe_master_inst.put(a, k);
        acks[0] = k;
        for (int i = 0; i < nb; i++) begin
            dacfe_master_inst.put(i < 3 ? w[23-8*i -: 8] : 8'hA5, k);
            acks[i+1] = k;
        end
        dacfe_master_inst.stop();
    endtask
    task automatic wr(input logic [6:0] a, input logic [3:0] c, input logic [11:0] v);
        logic [4:0] k;
        xfer({a, 1'b0}, {c, 4'h0, v, 4'h0}, 3, k);
        check(k, 5'h0F);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic s_sense();
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 9; i++) begin
            resetn <= 1'b0;
            st1 <= 2'(i / 3);
            st0 <= 2'(i % 3);
            ref_sel <= 1'(i);
            repeat (6) @(posedge clock);
            resetn <= 1'b1;
            d = 32'h0;
            for (int n = 0; n < 30 && !d[8]; n++)
                axi_rd(OFS_STATUS, d, r);
            if (!d[8]) begin
                failures++;
                conclude();
            end
            check(d[10:0], {4'h6, ADDR_TABLE[i]});
            check(dac_code, 32'h0);
            check({ref_b, dac_b}, {1'(i), 12'h800});
            wr(ADDR_TABLE[i], CMD_WR_UPD, 12'(i * 273));
            check(dac_code, i * 273);
            check(dac_b, i < 3 ? i * 273 : 32'h800);
            @(posedge clock);
        end
    endtask
    task automatic s_cmds();
        logic [4:0] k;
        xfer({ADDR_GLOBAL, 1'b0}, {CMD_PWR_DOWN, 20'h0}, 4, k);
        check(k, 5'h0F);
        check(dac_pd, 1'b1);
        wr(7'h30, CMD_WRITE, 12'h5A5);
        check(dac_code, 32'h888);
        wr(7'h30, CMD_UPDATE, 12'h000);
        check({dac_pd, dac_code}, 32'h5A5);
        wr(ADDR_GLOBAL, CMD_REF_EXT, 12'h000);
        @(posedge clock);
        ref_sel <= 1'b1;
        wr(7'h30, 4'hF, 12'h0F0);
        check({ref_internal, dac_code}, 32'h5A5);
        check(ref_b, 1'b0);
        wr(7'h30, CMD_REF_INT, 12'h000);
        check(ref_internal, 1'b1);
        xfer(8'h61, 24'h0, 0, k);
        check(k, 5'h00);
        xfer(8'hAA, 24'h0, 1, k);
        check(k, 5'h00);
        xfer(8'h60, {CMD_WR_UPD, 20'h12300}, 2, k);
        check({k, dac_code}, {5'h07, 12'h5A5});
    endtask
    task automatic s_bus();
        logic [31:0] d;
        logic [1:0] r;
        logic [4:0] k;
        axi_wr(OFS_CTRL, 32'h0, r);
        check(r, RESP_OKAY);
        xfer(8'h60, 24'h0, 1, k);
        check(k, 5'h00);
        axi_wr(OFS_CTRL, 32'h1, r);
        axi_rd(OFS_CTRL, d, r);
        check(d[0], 1'b1);
        axi_rd(4'hC, d, r);
        check(r, RESP_SLVERR);
        check(d, 32'h0);
        axi_wr(4'hC, 32'h1, r);
        check(r, RESP_SLVERR);
    endtask
    initial begin
        s_sense();
        s_cmds();
        s_bus();
        conclude();
    end
endmodule
